/* hdl/ssud_regs.vh */
// Purpose: Register map, field positions, reset values and timing counts.
// Assumes: 32-bit APB, one register per aligned word, data in bits 7:0.
// Notes: Included by ssud_top.v only.
`ifndef SSUD_REGS_VH
`define SSUD_REGS_VH
`define SSUD_OFF_CTRLH 8'h00
`define SSUD_OFF_FMT 8'h04
`define SSUD_OFF_PIN 8'h08
`define SSUD_OFF_EN 8'h0C
`define SSUD_OFF_STAT 8'h10
`define SSUD_OFF_RXB 8'h14
`define SSUD_OFF_TXB 8'h18
`define SSUD_CH_RATE 2:0
`define SSUD_CH_SOFTWARE_RESET_BIT 4
`define SSUD_CH_STOP 5
`define SSUD_CH_MSS 6
`define SSUD_FM_ORDER 0
`define SSUD_FM_PHASE 1
`define SSUD_FM_POL 2
`define SSUD_PM_CKSEL 0
`define SSUD_PM_BIDIR 1
`define SSUD_PM_FOUR 2
`define SSUD_EN_RIE 0
`define SSUD_EN_TRANSMIT_END_IRQ_ENABLE 1
`define SSUD_EN_TIE 2
`define SSUD_EN_RE 3
`define SSUD_EN_TE 4
`define SSUD_ST_OVR 2
`define SSUD_ST_RECEIVE_FULL_FLAG 5
`define SSUD_ST_TRANSMIT_END_FLAG 6
`define SSUD_ST_TRANSMIT_EMPTY_FLAG 7
`define SSUD_RST_BUF 8'hFF
`define SSUD_RST_CTRL 8'h00
`define SSUD_RST_SHIFT 8'h00
`define SSUD_RATE_MAX 3'h6
`define SSUD_HALF_BASE 8'h02
`define SSUD_FRAME_BITS 4'h8
`endif

/* hdl/ssud_top.v */
// Purpose: 8-bit synchronous serial unit data path with APB register access.
// Assumes: ref_clk 50 MHz; serial pins are asynchronous and synchronised here.
// Notes: Standby input reinitialises buffers, shift register and status.
// Functional notes
// - On overrun keep the held receive byte, drop the new one.
// - Overrun blocks reception; as master it also blocks transmission.
// - Receive buffer: 8 bits, read-only, resets to FF, reinit in standby.
// - Full byte moves shift register to receive buffer; reception continues.
// - Transmit buffer: 8-bit RW, FF reset; empty shifter loads it and starts.
// - With LSB-first order, transmit buffer reads back bit-reversed.
// - Shift register has no CPU access and clears in standby.
// - Master drives clock at seven rates; slave takes clock from pin.
// - Bit order control 1 shifts LSB first, 0 shifts MSB first.
// - Pin roles follow mode, bidirectional, master and enable bits.
// - Clear enables before reconfig; clearing transmit enable sets empty flag.
// - Transmit buffer write clears empty flag, loads shifter, sets flag, starts.
// - Frame end loads next byte, else set end flag; clock idles high, low in four-line mode with polarity bit set.
// - Master receive starts on a dummy read of the receive buffer.
// - Eight bits received: store, set full flag; buffer read clears it.
// - Stop bit ends master reception after the current byte.
// - Eighth clock with full flag set raises overrun and stops.
// - Combined mode starts on write, stops on empty or overrun at frame end.
//
// Register access over APB and the register offsets were decided locally.
`include "ssud_regs.vh"
module ssud_top #(
	parameter AW = 8
) (
	input wire ref_clk,
	input wire rst,
	input wire standby,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire serial_clock_pin_i,
	output wire serial_clock_pin_o,
	output wire serial_clock_pin_oe,
	input wire serial_data_pin_a_i,
	output wire serial_data_pin_a_o,
	output wire serial_data_pin_a_oe,
	input wire serial_data_pin_b_i,
	output wire serial_data_pin_b_o,
	output wire serial_data_pin_b_oe,
	output wire transmit_empty_irq,
	output wire transmit_end_irq,
	output wire receive_full_irq,
	output wire overrun_irq
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	function dec;
		input [AW-1:0] a;
		input [AW-1:0] off;
		begin
			dec = (a == off);
		end
	endfunction

	function [7:0] rev8;
		input [7:0] d;
		integer i;
		begin
			rev8 = 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				rev8[i] = d[7-i];
			end
		end
	endfunction

	reg [7:0] ctrlh_r;
	reg [7:0] fmt_r;
	reg [7:0] pin_r;
	reg [7:0] en_r;
	reg [7:0] rxbuf_r;
	reg [7:0] txbuf_r;
	reg [7:0] sr_r;
	reg ovr_r;
	reg receive_full_flag_r;
	reg transmit_end_flag_r;
	reg transmit_empty_flag_r;
	reg [1:0] st_r;
	reg [3:0] cnt_r;
	reg [7:0] div_r;
	reg sck_r;
	reg dout_r;
	reg rx_go_r;
	reg is_tx_r;
	reg is_rx_r;
	reg [2:0] sck_s_r;
	reg [1:0] a_s_r;
	reg [1:0] b_s_r;

	wire master = ctrlh_r[`SSUD_CH_MSS];
	wire order = fmt_r[`SSUD_FM_ORDER];
	wire phase = fmt_r[`SSUD_FM_PHASE];
	wire four = pin_r[`SSUD_PM_FOUR];
	wire bidir = pin_r[`SSUD_PM_BIDIR];
	wire te = en_r[`SSUD_EN_TE];
	wire re = en_r[`SSUD_EN_RE];
	wire software_reset_bit = ctrlh_r[`SSUD_CH_SOFTWARE_RESET_BIT];
	wire idle_lvl = ~(four & fmt_r[`SSUD_FM_POL]);
	wire run = st_r[1];

	// Rate code 7 is not a valid rate; treat it as the slowest one
	wire [2:0] rate = (ctrlh_r[`SSUD_CH_RATE] > `SSUD_RATE_MAX) ?
		`SSUD_RATE_MAX : ctrlh_r[`SSUD_CH_RATE];
	wire [7:0] half = `SSUD_HALF_BASE << rate;
	wire tick = run & master & (div_r == half - 8'h01);
	wire m_lead = tick & (sck_r == idle_lvl);
	wire m_trail = tick & (sck_r != idle_lvl);
	// Only the second and third stages are compared; the first stage may be metastable
	wire s_edge = sck_s_r[2] ^ sck_s_r[1];
	wire s_lead = s_edge & (sck_s_r[1] != idle_lvl);
	wire s_trail = s_edge & (sck_s_r[1] == idle_lvl);
	wire lead_e = run & (master ? m_lead : s_lead);
	wire trail_e = run & (master ? m_trail : s_trail);
	wire samp = phase ? trail_e : lead_e;
	wire chg = phase ? lead_e : trail_e;
	wire frame_end = trail_e & (cnt_r == `SSUD_FRAME_BITS);

	// Pin roles per mode; disused pins are left undriven for general I/O
	wire rx_from_b = four & (bidir | ~master);
	wire tx_on_a = four & ~bidir & ~master;
	wire din = rx_from_b ? b_s_r[1] : a_s_r[1];
	wire [7:0] sr_shift = order ? {din, sr_r[7:1]} : {sr_r[6:0], din};
	wire [7:0] rx_byte = phase ? sr_shift : sr_r;
	wire tx_first = order ? txbuf_r[0] : txbuf_r[7];

	wire ovr_hit = is_rx_r & receive_full_flag_r;
	wire tx_more = is_tx_r & ~transmit_empty_flag_r & ~ovr_hit & ~(ovr_r & master);
	wire stop_now = ovr_hit | (is_tx_r ? ~tx_more : (master & ctrlh_r[`SSUD_CH_STOP]));

	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire rd_rx = rd & dec(paddr, `SSUD_OFF_RXB);
	wire [7:0] stat = {transmit_empty_flag_r, transmit_end_flag_r, receive_full_flag_r, 2'b00, ovr_r, 2'b00};
	wire mapped = dec(paddr, `SSUD_OFF_CTRLH) | dec(paddr, `SSUD_OFF_FMT) |
		dec(paddr, `SSUD_OFF_PIN) | dec(paddr, `SSUD_OFF_EN) |
		dec(paddr, `SSUD_OFF_STAT) | dec(paddr, `SSUD_OFF_RXB) |
		dec(paddr, `SSUD_OFF_TXB);

	// Slave answers in the first access cycle; read data is caught at setup
	assign pready = 1'b1;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= ~mapped;
			if (dec(paddr, `SSUD_OFF_CTRLH)) begin
				prdata <= {24'h000000, ctrlh_r};
			end else if (dec(paddr, `SSUD_OFF_FMT)) begin
				prdata <= {24'h000000, fmt_r};
			end else if (dec(paddr, `SSUD_OFF_PIN)) begin
				prdata <= {24'h000000, pin_r};
			end else if (dec(paddr, `SSUD_OFF_EN)) begin
				prdata <= {24'h000000, en_r};
			end else if (dec(paddr, `SSUD_OFF_STAT)) begin
				prdata <= {24'h000000, stat};
			end else if (dec(paddr, `SSUD_OFF_RXB)) begin
				prdata <= {24'h000000, rxbuf_r};
			end else if (dec(paddr, `SSUD_OFF_TXB)) begin
				prdata <= {24'h000000, order ? rev8(txbuf_r) : txbuf_r};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sck_s_r <= 3'h7;
			a_s_r <= 2'h0;
			b_s_r <= 2'h0;
		end else begin
			sck_s_r <= {sck_s_r[1:0], serial_clock_pin_i};
			a_s_r <= {a_s_r[0], serial_data_pin_a_i};
			b_s_r <= {b_s_r[0], serial_data_pin_b_i};
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrlh_r <= `SSUD_RST_CTRL;
			fmt_r <= `SSUD_RST_CTRL;
			pin_r <= `SSUD_RST_CTRL;
			en_r <= `SSUD_RST_CTRL;
			rxbuf_r <= `SSUD_RST_BUF;
			txbuf_r <= `SSUD_RST_BUF;
			sr_r <= `SSUD_RST_SHIFT;
			ovr_r <= 1'b0;
			receive_full_flag_r <= 1'b0;
			transmit_end_flag_r <= 1'b0;
			transmit_empty_flag_r <= 1'b1;
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			div_r <= 8'h00;
			sck_r <= 1'b1;
			dout_r <= 1'b1;
			rx_go_r <= 1'b0;
			is_tx_r <= 1'b0;
			is_rx_r <= 1'b0;
		end else if (standby) begin
			rxbuf_r <= `SSUD_RST_BUF;
			txbuf_r <= `SSUD_RST_BUF;
			sr_r <= `SSUD_RST_SHIFT;
			ovr_r <= 1'b0;
			receive_full_flag_r <= 1'b0;
			transmit_end_flag_r <= 1'b0;
			transmit_empty_flag_r <= 1'b1;
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			div_r <= 8'h00;
			sck_r <= idle_lvl;
			rx_go_r <= 1'b0;
		end else begin
			if (wr & dec(paddr, `SSUD_OFF_CTRLH)) begin
				ctrlh_r <= pwdata[7:0];
			end
			if (wr & dec(paddr, `SSUD_OFF_FMT)) begin
				fmt_r <= pwdata[7:0];
			end
			if (wr & dec(paddr, `SSUD_OFF_PIN)) begin
				pin_r <= pwdata[7:0];
			end
			if (wr & dec(paddr, `SSUD_OFF_EN)) begin
				en_r <= pwdata[7:0];
			end
			// Software clears come first so a hardware set in the same cycle wins
			if (wr & dec(paddr, `SSUD_OFF_STAT)) begin
				if (~pwdata[`SSUD_ST_OVR]) begin
					ovr_r <= 1'b0;
				end
				if (~pwdata[`SSUD_ST_TRANSMIT_END_FLAG]) begin
					transmit_end_flag_r <= 1'b0;
				end
			end
			if (rd_rx) begin
				receive_full_flag_r <= 1'b0;
				if (re & master) begin
					rx_go_r <= 1'b1;
				end
			end
			case (st_r)
			ST_IDLE: begin
				sck_r <= idle_lvl;
				div_r <= 8'h00;
				cnt_r <= 4'h0;
				if (software_reset_bit) begin
					rx_go_r <= 1'b0;
				end else if (te & ~transmit_empty_flag_r & ~(ovr_r & (master | re))) begin
					sr_r <= txbuf_r;
					transmit_empty_flag_r <= 1'b1;
					dout_r <= tx_first;
					st_r <= ST_RUN;
					is_tx_r <= 1'b1;
					is_rx_r <= re;
					rx_go_r <= 1'b0;
				end else if (re & ~te & ~ovr_r & (~master | rx_go_r)) begin
					st_r <= ST_RUN;
					is_tx_r <= 1'b0;
					is_rx_r <= 1'b1;
					rx_go_r <= 1'b0;
				end else if (ovr_r) begin
					// A read refused during overrun must not start a frame once cleared
					rx_go_r <= 1'b0;
				end
			end
			ST_RUN: begin
				div_r <= tick ? 8'h00 : div_r + 8'h01;
				if (tick) begin
					sck_r <= ~sck_r;
				end
				if (samp) begin
					sr_r <= sr_shift;
					cnt_r <= cnt_r + 4'h1;
				end
				if (chg & (cnt_r != 4'h0) & (cnt_r != `SSUD_FRAME_BITS)) begin
					dout_r <= order ? sr_r[0] : sr_r[7];
				end
				if (frame_end) begin
					cnt_r <= 4'h0;
					if (is_rx_r) begin
						if (receive_full_flag_r) begin
							ovr_r <= 1'b1;
						end else begin
							rxbuf_r <= rx_byte;
							receive_full_flag_r <= 1'b1;
						end
					end
					if (tx_more) begin
						sr_r <= txbuf_r;
						transmit_empty_flag_r <= 1'b1;
						dout_r <= tx_first;
					end else if (is_tx_r) begin
						transmit_end_flag_r <= 1'b1;
					end
					if (stop_now) begin
						st_r <= ST_IDLE;
						sck_r <= idle_lvl;
					end
				end
				if ((~te & ~re) | software_reset_bit) begin
					st_r <= ST_IDLE;
					sck_r <= idle_lvl;
				end
			end
			default: begin
				st_r <= ST_IDLE;
			end
			endcase
			// A buffer write after the load marks new data, so it overrides the set
			if (wr & dec(paddr, `SSUD_OFF_TXB)) begin
				txbuf_r <= pwdata[7:0];
				if (te) begin
					transmit_empty_flag_r <= 1'b0;
				end
			end
			if (wr & dec(paddr, `SSUD_OFF_EN) & ~pwdata[`SSUD_EN_TE]) begin
				transmit_empty_flag_r <= 1'b1;
			end
		end
	end

	assign serial_clock_pin_o = sck_r;
	assign serial_clock_pin_oe = master & pin_r[`SSUD_PM_CKSEL];
	assign serial_data_pin_a_o = dout_r;
	assign serial_data_pin_a_oe = te & tx_on_a;
	assign serial_data_pin_b_o = dout_r;
	assign serial_data_pin_b_oe = te & ~tx_on_a & ~(four & ~bidir & ~master);
	assign transmit_empty_irq = en_r[`SSUD_EN_TIE] & transmit_empty_flag_r;
	assign transmit_end_irq = en_r[`SSUD_EN_TRANSMIT_END_IRQ_ENABLE] & transmit_end_flag_r;
	assign receive_full_irq = en_r[`SSUD_EN_RIE] & receive_full_flag_r;
	assign overrun_irq = en_r[`SSUD_EN_RIE] & ovr_r;
endmodule

/* dv/ssud_top_checker.sv */
// Purpose: Port-level checks for ssud_top.
// Assumes: Control bits are mirrored from APB writes at the access edge.
// Notes: Four-line mode is never set by the bench, so idle clock is high.
module ssud_chk (
	input wire ref_clk,
	input wire rst,
	input wire standby,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire serial_clock_pin_o,
	input wire serial_clock_pin_oe,
	input wire serial_data_pin_a_oe,
	input wire serial_data_pin_b_oe,
	input wire transmit_empty_irq,
	input wire transmit_end_irq,
	input wire receive_full_irq,
	input wire overrun_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic mss_r, te_r, ck_r, four_r;
	wire wr = psel && penable && pwrite;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{mss_r, te_r, ck_r, four_r} <= 4'h0;
		end else if (wr && paddr == 8'h00) begin
			mss_r <= pwdata[6];
		end else if (wr && paddr == 8'h08) begin
			{four_r, ck_r} <= {pwdata[2], pwdata[0]};
		end else if (wr && paddr == 8'h0C) begin
			te_r <= pwdata[4];
		end
	end
	property p_ck_oe; serial_clock_pin_oe == (mss_r && ck_r); endproperty
	a_ck_oe: assert property (p_ck_oe) else $error("clock pin enable wrong");
	property p_pins; !four_r |-> !serial_data_pin_a_oe && serial_data_pin_b_oe == te_r; endproperty
	a_pins: assert property (p_pins) else $error("data pin roles wrong");
	property p_te_off; wr && paddr == 8'h0C && !pwdata[4] |=> transmit_empty_irq == $past(pwdata[2]);
	endproperty
	a_te_off: assert property (p_te_off) else $error("empty flag not set");
	property p_rd_clr; psel && penable && !pwrite && paddr == 8'h14 |=> !receive_full_irq; endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("full flag not cleared");
	property p_stby; standby |=> !receive_full_irq && !overrun_irq && !transmit_end_irq; endproperty
	a_stby: assert property (p_stby) else $error("standby left flags");
	property p_ovr; overrun_irq && $past(overrun_irq) |-> $stable(serial_clock_pin_o); endproperty
	a_ovr: assert property (p_ovr) else $error("clock runs in overrun");
	property p_transmit_end_flag; transmit_end_irq && !four_r |-> serial_clock_pin_o; endproperty
	a_transmit_end_flag: assert property (p_transmit_end_flag) else $error("clock not high at end");
	property p_start; wr && paddr == 8'h18 && te_r && mss_r && transmit_end_irq && !overrun_irq
		|-> ##[1:300] !serial_clock_pin_o; endproperty
	a_start: assert property (p_start) else $error("transmit did not start");
	c_transmit_end_flag: cover property (transmit_end_irq);
	c_full: cover property (receive_full_irq);
	c_ovr: cover property (overrun_irq);
endmodule
bind ssud_top ssud_chk u_chk (.ref_clk, .rst, .standby, .psel, .penable, .pwrite, .paddr, .pwdata,
	.serial_clock_pin_o, .serial_clock_pin_oe, .serial_data_pin_a_oe, .serial_data_pin_b_oe,
	.transmit_empty_irq, .transmit_end_irq, .receive_full_irq, .overrun_irq);

/* dv/ssud_peer.sv */
// Purpose: Serial peer, shifts MSB first on an idle-high clock.
// Assumes: Phase 0: sample on the falling edge, change on the rising edge.
// Notes: After a frame it keeps shifting new bits, never the stale one.
module ssud_peer (
	input wire sck,
	input wire sdi,
	output logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_r = 8'hFF;
	logic [7:0] rx_r;
	assign sdo = tx_r[7];
	always @(negedge sck) rx_r <= {rx_r[6:0], sdi};
	always @(posedge sck) tx_r <= {tx_r[6:0], ~tx_r[7]};
endmodule

/* dv/ssud_top_tb_top.sv */
// Purpose: Self-checking bench for ssud_top.
// Assumes: Rate 1 master clock, phase 0, clocked synchronous mode.
// Notes: Link clock runs only inside slave frames.
module ssud_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, standby = 0, psel = 0, penable = 0, pwrite = 0, lk = 1;
	logic [7:0] paddr = 8'h00;
	logic [7:0] rd;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, err, ck_o, ck_oe, a_o, a_oe, b_o, b_oe, p_sdo;
	int fails = 0, num_checks = 0, cyc = 0;
	wire sck = ck_oe ? ck_o : lk;
	wire pin_a = a_oe ? a_o : p_sdo;
	wire pin_b = b_oe ? b_o : 1'b1;
	initial forever #10 ref_clk = ~ref_clk;
	ssud_top dut (.ref_clk, .rst, .standby, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .serial_clock_pin_i(sck), .serial_clock_pin_o(ck_o),
		.serial_clock_pin_oe(ck_oe), .serial_data_pin_a_i(pin_a), .serial_data_pin_a_o(a_o),
		.serial_data_pin_a_oe(a_oe), .serial_data_pin_b_i(pin_b), .serial_data_pin_b_o(b_o),
		.serial_data_pin_b_oe(b_oe), .transmit_empty_irq(), .transmit_end_irq(),
		.receive_full_irq(), .overrun_irq());
	ssud_peer u_peer (.sck(sck), .sdi(pin_b), .sdo(p_sdo));
	task automatic report_and_stop();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wst(int b);
		int i;
		i = 0;
		do begin
			bus(0, 8'h10, 8'h00);
			i++;
		end while (rd[b] !== 1'b1 && i < 400);
		chk("status bit", 8'h01, {7'h00, rd[b]});
	endtask
	task automatic lframe();
		repeat (8) begin
			lk <= 1'b0;
			repeat (4) @(posedge ref_clk);
			lk <= 1'b1;
			repeat (4) @(posedge ref_clk);
		end
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 0;
		bus(0, 8'h14, 8'h00);
		chk("rx buf", 8'hFF, rd);
		bus(1, 8'h14, 8'h55);
		bus(0, 8'h14, 8'h00);
		chk("rx buf ro", 8'hFF, rd);
		bus(0, 8'h18, 8'h00);
		chk("tx buf", 8'hFF, rd);
		bus(0, 8'h40, 8'h00);
		chk("unmapped", 8'h01, {7'h00, err});
		bus(1, 8'h04, 8'h01);
		bus(1, 8'h18, 8'h1E);
		bus(0, 8'h18, 8'h00);
		chk("tx reversed", 8'h78, rd);
		bus(1, 8'h08, 8'h01);
		bus(1, 8'h00, 8'h41);
		for (int o = 0; o < 2; o++) begin
			bus(1, 8'h0C, 8'h00);
			bus(1, 8'h04, o[7:0]);
			bus(1, 8'h0C, 8'h16);
			bus(1, 8'h18, 8'h1E);
			bus(1, 8'h10, 8'h80);
			wst(6);
			chk("peer rx", o ? 8'h78 : 8'h1E, u_peer.rx_r);
		end
		bus(1, 8'h18, 8'h1E);
		bus(1, 8'h10, 8'h80);
		bus(1, 8'h18, 8'hC5);
		wst(6);
		chk("peer rx 2nd", 8'hA3, u_peer.rx_r);
		bus(1, 8'h0C, 8'h00);
		bus(1, 8'h04, 8'h00);
		bus(1, 8'h10, 8'h80);
		bus(1, 8'h0C, 8'h09);
		u_peer.tx_r = 8'h3C;
		bus(0, 8'h14, 8'h00);
		wst(5);
		wst(2);
		bus(0, 8'h14, 8'h00);
		chk("rx kept", 8'h3C, rd);
		repeat (100) @(posedge ref_clk);
		bus(0, 8'h10, 8'h00);
		chk("rx blocked", 8'h04, rd & 8'h24);
		bus(1, 8'h10, 8'h80);
		bus(1, 8'h00, 8'h61);
		u_peer.tx_r = 8'h96;
		bus(0, 8'h14, 8'h00);
		wst(5);
		repeat (200) @(posedge ref_clk);
		bus(0, 8'h10, 8'h00);
		chk("rx stopped", 8'h20, rd & 8'h24);
		bus(0, 8'h14, 8'h00);
		chk("rx last", 8'h96, rd);
		bus(1, 8'h0C, 8'h00);
		bus(1, 8'h00, 8'h00);
		bus(1, 8'h10, 8'h80);
		bus(1, 8'h0C, 8'h08);
		u_peer.tx_r = 8'hC3;
		lframe();
		wst(5);
		bus(0, 8'h14, 8'h00);
		chk("slave rx", 8'hC3, rd);
		bus(1, 8'h0C, 8'h00);
		bus(1, 8'h00, 8'h41);
		bus(1, 8'h10, 8'h80);
		bus(0, 8'h10, 8'h00);
		chk("combined idle", 8'h80, rd);
		bus(1, 8'h0C, 8'h18);
		u_peer.tx_r = 8'h5A;
		bus(1, 8'h18, 8'hA5);
		wst(6);
		chk("combined tx", 8'hA5, u_peer.rx_r);
		bus(0, 8'h14, 8'h00);
		chk("combined rx", 8'h5A, rd);
		bus(1, 8'h0C, 8'h00);
		bus(1, 8'h18, 8'h12);
		standby <= 1'b1;
		repeat (2) @(posedge ref_clk);
		standby <= 1'b0;
		bus(0, 8'h18, 8'h00);
		chk("tx standby", 8'hFF, rd);
		bus(0, 8'h14, 8'h00);
		chk("rx standby", 8'hFF, rd);
		report_and_stop();
	end
endmodule
